// *** src/fmw_pkg.sv ***
// constants and carrier types for the fault mode and wake timing block
//
// Operation
// - leaving fail-safe sets the failure flag; fail output stays active until cleared
// - undervoltage or watchdog failure in normal or stop goes to restart
// - overvoltage in normal or stop goes to restart or fail-safe per setting
// - sleep request with no wake source enabled goes to restart instead
// - upper thermal shutdown sends the device to fail-safe
// - main regulator shorted to ground sends the device to fail-safe
// - fourth consecutive watchdog failure sends the device to fail-safe
// - fourth consecutive undervoltage event sends the device to fail-safe
// - fail-safe drives the shared pin only when configured as fail output
// - sensed wake input change interrupts in normal/stop, wakes from sleep
// - initial level sets the high-side output before cyclic sense starts
// - cyclic sense starts on any enabling on-time, whatever else is set
// - on-time above period sets the command error flag
// - wake inputs sampled once per cycle at end of on-time
// - cyclic sense wake sets the flag of that wake input
// - during cyclic sense the level status holds only sampled levels
// - wake event raised even if the input flag is already set
// - fail-safe stops cyclic sense; high-side faults disable that output
// - sleep request with wake or drain flags set wakes through restart
// - cyclic wake interrupts in normal/stop, wakes through restart from sleep
// - cyclic wake on-time is only an enable; 000, 110, 111 mean off
// - cyclic wake interrupts at each on-time start except the first
// - reset output held low throughout restart
// - restart moves to normal on its own once reset is released
package fmw_pkg;
   // timing
   localparam int CLK_MHZ = 100;
   localparam int T_RESTART_NS = 10000;
   localparam int RESTART_CYC = (T_RESTART_NS * CLK_MHZ + 999) / 1000;
   localparam int T_TICK_NS = 1000;
   localparam int TICK_CYC = (T_TICK_NS * CLK_MHZ + 999) / 1000;
   localparam int T_INT_NS = 100;
   localparam int INT_CYC = (T_INT_NS * CLK_MHZ + 999) / 1000;
   localparam logic [2:0] FAIL_CNT = 3'h3; // three failures seen before the fourth
   // register offsets
   localparam logic [3:0] A_STATE = 4'h0;
   localparam logic [3:0] A_FLAG = 4'h1;
   localparam logic [3:0] A_CFG = 4'h2;
   localparam logic [3:0] A_MAP = 4'h3;
   localparam logic [3:0] A_TMR0 = 4'h4;
   localparam logic [3:0] A_TMR1 = 4'h5;
   localparam logic [3:0] A_WAKE = 4'h6;
   // on-time codes that leave a timer off
   localparam logic [2:0] ON_OFF = 3'h0;
   localparam logic [2:0] ON_RSV6 = 3'h6;
   localparam logic [2:0] ON_RSV7 = 3'h7;
   // timer selection codes
   localparam logic [1:0] SEL_NONE = 2'h0;
   localparam logic [1:0] SEL_T0 = 2'h1;
   localparam logic [1:0] SEL_T1 = 2'h2;

   typedef enum logic [4:0] {
      ST_NORMAL = 5'b00001,
      ST_STOP = 5'b00010,
      ST_SLEEP = 5'b00100,
      ST_RESTART = 5'b01000,
      ST_FAIL = 5'b10000
   } fmw_state_e;
   typedef enum logic [1:0] {
      REQ_NONE = 2'h0,
      REQ_NORMAL = 2'h1,
      REQ_STOP = 2'h2,
      REQ_SLEEP = 2'h3
   } fmw_req_e;

   typedef struct packed {logic [3:0] addr; logic [15:0] wdata; logic wr; logic rd;} fmw_bus_s;
   typedef struct packed {
      logic uv; logic ov; logic wdFail; logic wdOk; logic tsdHi; logic scGnd;
      logic [1:0] hsFault; logic drain_monitor_status;
   } fmw_fault_s;
   typedef struct packed {logic [13:0] pad; fmw_req_e req;} fmw_cmd_s;
   typedef struct packed {
      logic [7:0] pad; logic [2:0] uvCnt; logic [2:0] wdCnt; logic cmdErr; logic failure;
   } fmw_flag_s;
   typedef struct packed {
      logic [9:0] pad; logic [1:0] cwEn; logic [1:0] wakeEn; logic foSel; logic ovSel;
   } fmw_cfg_s;
   typedef struct packed {
      logic [5:0] pad; logic [1:0][1:0] wkSel; logic [1:0] hsInit; logic [1:0][1:0] hsSel;
   } fmw_map_s;
   typedef struct packed {logic [4:0] pad; logic [2:0] onCode; logic [7:0] period;} fmw_tmr_s;
   typedef struct packed {
      logic [10:0] pad; logic drain_monitor_status; logic [1:0] lvl; logic [1:0] flag;
   } fmw_wake_s;

   // whole state of the core
   typedef struct packed {
      fmw_state_e st;
      logic [11:0] cnt;
      logic [2:0] wdCnt;
      logic [2:0] uvCnt;
      logic failFlag;
      logic cmdErr;
      fmw_cfg_s cfg;
      fmw_map_s map;
      fmw_tmr_s [1:0] tmr;
      logic [1:0][7:0] tCnt;
      logic [7:0] pre;
      logic [1:0] wkS1;
      logic [1:0] wkS2;
      logic [1:0] wkS3;
      logic [1:0] wkLvl;
      logic [1:0] lvlStat;
      logic [1:0] wkFlag;
      logic [3:0] intCnt;
      logic interrupt_out_n;
      logic reset_out_n;
      logic failOut;
      logic pinOut;
      logic pinOeN;
      logic [1:0] hsOut;
      logic [15:0] rdata;
   } fmw_core_s;

   // an on-time code enables its timer unless it is one of the off codes
   function automatic logic fmw_on_ok(input logic [2:0] c);
      return !(c == ON_OFF || c == ON_RSV6 || c == ON_RSV7);
   endfunction : fmw_on_ok
endpackage : fmw_pkg

// *** src/fmw_core.sv ***
// fault mode sequencing, cyclic sense and cyclic wake timers
`timescale 1ns/1ps
`default_nettype none
module fmw_core (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // register port
   input wire fmw_pkg::fmw_bus_s bus,
   output logic [15:0] rdata,
   // on-chip monitor event pulses
   input wire fmw_pkg::fmw_fault_s fault,
   // wake pins, bit 1 is the shared fail/wake pin input
   input wire logic [1:0] wakeIn,
   // host signals
   output logic interruptOutN,
   output logic resetOutN,
   output logic failOutput,
   // shared fail/wake pin driver
   output logic failPinOut,
   output logic failPinOeN,
   // high-side outputs
   output logic [1:0] highSideOut
);
   import fmw_pkg::*;

   // ****************************************************************
   // reset release and state
   // ****************************************************************
   logic rstMeta;
   logic rstSync;
   fmw_core_s r;
   fmw_core_s n;

   // two-flop release of the asynchronous reset
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rstMeta <= 1'b0;
         rstSync <= 1'b0;
      end
      else
      begin
         rstMeta <= 1'b1;
         rstSync <= rstMeta;
      end
   end

   // ****************************************************************
   // combinational helpers
   // ****************************************************************
   logic tick;
   logic [1:0] tEn;
   logic [1:0] tOn;
   logic [1:0] tStart;
   logic [1:0] tEnd;
   logic [1:0] wkEv;
   logic cwEv;
   logic crit;
   logic hardFail;
   logic softFault;
   logic noSource;
   logic flagsSet;
   logic [7:0] tNext;
   logic [1:0] newLvl;
   logic cyc;
   logic tSel;
   fmw_req_e req;
   fmw_flag_s fw;
   fmw_wake_s ww;
   fmw_tmr_s tw;
   fmw_cmd_s cw;

   // next-state logic
   always_comb
   begin
      n = r;
      req = REQ_NONE;
      fw = fmw_flag_s'(bus.wdata);
      ww = fmw_wake_s'(bus.wdata);
      tw = fmw_tmr_s'(bus.wdata);
      cw = fmw_cmd_s'(bus.wdata);
      tNext = 8'h00;
      cyc = 1'b0;
      tSel = 1'b0;
      // prescaler for the timer tick
      tick = (r.pre == 8'(TICK_CYC - 1));
      n.pre = tick ? 8'h00 : r.pre + 8'h01;
      // two timers; enabling is itself the first start and raises no event
      for (int t = 0; t < 2; t++)
      begin
         tEn[t] = fmw_on_ok(r.tmr[t].onCode);
         tNext = (r.tCnt[t] + 8'h01 >= r.tmr[t].period) ? 8'h00 : r.tCnt[t] + 8'h01;
         tOn[t] = tEn[t] && (r.tCnt[t] < {5'h00, r.tmr[t].onCode});
         tStart[t] = tEn[t] && tick && (tNext == 8'h00);
         tEnd[t] = tEn[t] && tick && (r.tCnt[t] + 8'h01 == {5'h00, r.tmr[t].onCode});
         n.tCnt[t] = !tEn[t] ? 8'h00 : (tick ? tNext : r.tCnt[t]);
      end
      // cyclic wake event from either timer
      cwEv = |(r.cfg.cwEn & tStart);
      // wake input filtering and sensing
      for (int i = 0; i < 2; i++)
      begin
         newLvl[i] = (r.wkS2[i] == r.wkS3[i]) ? r.wkS3[i] : r.wkLvl[i];
         cyc = (r.map.wkSel[i] == SEL_T0) || (r.map.wkSel[i] == SEL_T1);
         tSel = (r.map.wkSel[i] == SEL_T1);
         wkEv[i] = 1'b0;
         if (cyc)
         begin
            // level status holds only what was sampled at the end of on-time
            if (tEnd[tSel])
            begin
               n.lvlStat[i] = r.wkLvl[i];
               wkEv[i] = (r.wkLvl[i] != r.lvlStat[i]);
            end
         end
         else
         begin
            n.lvlStat[i] = newLvl[i];
            wkEv[i] = r.cfg.wakeEn[i] && (newLvl[i] != r.wkLvl[i]);
         end
      end
      n.wkLvl = newLvl;
      // synchroniser chain for the wake pins
      n.wkS1 = wakeIn;
      n.wkS2 = r.wkS1;
      n.wkS3 = r.wkS2;
      // fault classes
      hardFail = fault.tsdHi || fault.scGnd;
      crit = hardFail || (fault.ov && r.cfg.ovSel)
         || (fault.wdFail && r.wdCnt == FAIL_CNT)
         || (fault.uv && r.uvCnt == FAIL_CNT);
      softFault = fault.uv || fault.wdFail || fault.ov;
      noSource = (r.cfg.wakeEn == 2'b00) && (r.cfg.cwEn == 2'b00)
         && (r.map.wkSel == '0);
      flagsSet = (r.wkFlag != 2'b00) || fault.drain_monitor_status;
      // ****************************************************************
      // register writes
      // ****************************************************************
      if (bus.wr)
      begin
         case (bus.addr)
            A_STATE: req = cw.req;
            A_FLAG:
            begin
               n.failFlag = r.failFlag && !fw.failure;
               n.cmdErr = r.cmdErr && !fw.cmdErr;
               if (fw.failure)
               begin
                  n.uvCnt = 3'h0;
               end
            end
            A_CFG: n.cfg = fmw_cfg_s'(bus.wdata);
            A_MAP: n.map = fmw_map_s'(bus.wdata);
            A_TMR0, A_TMR1:
            begin
               n.tmr[bus.addr == A_TMR1] = tw;
               if ({5'h00, tw.onCode} > tw.period)
               begin
                  n.cmdErr = 1'b1;
               end
            end
            A_WAKE: n.wkFlag = r.wkFlag & ~ww.flag;
            default: n.cfg = r.cfg;
         endcase
      end
      // wake flags: a new event wins over a clear in the same cycle
      n.wkFlag = n.wkFlag | wkEv;
      // high-side disable on a driver fault
      for (int h = 0; h < 2; h++)
      begin
         if (fault.hsFault[h])
         begin
            n.map.hsSel[h] = SEL_NONE;
            n.map.hsInit[h] = 1'b0;
         end
      end
      // watchdog failure counter
      if (fault.wdOk)
      begin
         n.wdCnt = 3'h0;
      end
      // ****************************************************************
      // mode sequencing
      // ****************************************************************
      case (r.st)
         ST_NORMAL, ST_STOP:
         begin
            if (fault.wdFail)
            begin
               n.wdCnt = r.wdCnt + 3'h1;
            end
            if (fault.uv)
            begin
               n.uvCnt = r.uvCnt + 3'h1;
            end
            if (crit)
            begin
               n.st = ST_FAIL;
            end
            else if (softFault)
            begin
               n.st = ST_RESTART;
            end
            else if (req == REQ_SLEEP)
            begin
               if (r.st == ST_STOP)
               begin
                  n.st = ST_RESTART;
                  n.cmdErr = 1'b1;
               end
               else if (noSource || flagsSet)
               begin
                  n.st = ST_RESTART;
               end
               else
               begin
                  n.st = ST_SLEEP;
               end
            end
            else if (req == REQ_STOP)
            begin
               n.st = ST_STOP;
            end
            else if (req == REQ_NORMAL)
            begin
               n.st = ST_NORMAL;
            end
            // sensed change or cyclic wake pulls the interrupt
            if ((|wkEv) || cwEv)
            begin
               n.intCnt = 4'(INT_CYC);
            end
         end
         ST_SLEEP:
         begin
            if (crit)
            begin
               n.st = ST_FAIL;
            end
            else if ((|wkEv) || cwEv || softFault)
            begin
               n.st = ST_RESTART;
            end
         end
         ST_RESTART:
         begin
            if (hardFail)
            begin
               n.st = ST_FAIL;
            end
            else if (r.cnt == 12'(RESTART_CYC - 1))
            begin
               n.st = ST_NORMAL;
            end
         end
         ST_FAIL:
         begin
            // cyclic sense stopped, inputs back to static sensing
            n.map.hsSel = '0;
            n.map.wkSel = '0;
            n.tmr[0].onCode = ON_OFF;
            n.tmr[1].onCode = ON_OFF;
            if ((|wkEv) && !hardFail)
            begin
               n.st = ST_RESTART;
               n.failFlag = 1'b1;
            end
         end
         default: n.st = ST_RESTART;
      endcase
      if (r.st == ST_FAIL && r.map.wkSel != '0)
      begin
         n.wkFlag = r.wkFlag;
      end
      // restart dwell counter
      n.cnt = (r.st == ST_RESTART && n.st == ST_RESTART) ? r.cnt + 12'h001 : 12'h000;
      // interrupt pulse stretcher
      if (n.intCnt == r.intCnt && r.intCnt != 4'h0)
      begin
         n.intCnt = r.intCnt - 4'h1;
      end
      n.interrupt_out_n = (n.intCnt == 4'h0);
      // reset low during restart, sleep and fail-safe
      n.reset_out_n = (n.st == ST_NORMAL) || (n.st == ST_STOP);
      n.failOut = n.failFlag || (n.st == ST_FAIL);
      n.pinOut = !n.failOut;
      n.pinOeN = !n.cfg.foSel;
      // high side: initial level until the mapped timer runs
      for (int h = 0; h < 2; h++)
      begin
         if (n.map.hsSel[h] == SEL_T0 || n.map.hsSel[h] == SEL_T1)
         begin
            n.hsOut[h] = tEn[n.map.hsSel[h] == SEL_T1]
               ? tOn[n.map.hsSel[h] == SEL_T1] : n.map.hsInit[h];
         end
         else
         begin
            n.hsOut[h] = 1'b0;
         end
      end
      // ****************************************************************
      // register reads, data valid the cycle after the strobe
      // ****************************************************************
      n.rdata = 16'h0000;
      if (bus.rd)
      begin
         case (bus.addr)
            A_STATE: n.rdata = {11'h000, r.st};
            A_FLAG: n.rdata = {8'h00, r.uvCnt, r.wdCnt, r.cmdErr, r.failFlag};
            A_CFG: n.rdata = r.cfg;
            A_MAP: n.rdata = r.map;
            A_TMR0: n.rdata = r.tmr[0];
            A_TMR1: n.rdata = r.tmr[1];
            A_WAKE: n.rdata = {11'h000, fault.drain_monitor_status, r.lvlStat, r.wkFlag};
            default: n.rdata = 16'h0000;
         endcase
      end
   end

   // state register
   always_ff @(posedge sys_clk or negedge rstSync)
   begin
      if (!rstSync)
      begin
         r <= '0;
         r.st <= ST_RESTART;
         r.interrupt_out_n <= 1'b1;
         r.pinOut <= 1'b1;
         r.pinOeN <= 1'b1;
      end
      else
      begin
         r <= n;
      end
   end

   // outputs straight from the state register
   assign rdata = r.rdata;
   assign interruptOutN = r.interrupt_out_n;
   assign resetOutN = r.reset_out_n;
   assign failOutput = r.failOut;
   assign failPinOut = r.pinOut;
   assign failPinOeN = r.pinOeN;
   assign highSideOut = r.hsOut;

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstSync);

   a_restart_rst: assert property (r.st == ST_RESTART |-> !resetOutN)
      else $error("reset output high in restart");
   a_restart_exit: assert property ((r.st == ST_RESTART && !hardFail
      && r.cnt == 12'(RESTART_CYC - 1)) |=> r.st == ST_NORMAL ##1 resetOutN)
      else $error("restart did not end in normal");
   a_fail_flag: assert property ((r.st == ST_FAIL && n.st == ST_RESTART)
      |=> r.failFlag && failOutput)
      else $error("failure flag not set on fail-safe exit");
   a_uv_restart: assert property ((r.st == ST_NORMAL && fault.uv && !crit)
      |=> r.st == ST_RESTART)
      else $error("undervoltage did not restart");
   a_ov_fail: assert property ((r.st == ST_STOP && fault.ov && r.cfg.ovSel)
      |=> r.st == ST_FAIL)
      else $error("overvoltage did not enter fail-safe");
   a_tsd_fail: assert property ((fault.tsdHi || fault.scGnd) |=> r.st == ST_FAIL)
      else $error("critical fault did not enter fail-safe");
   a_wd_fourth: assert property ((r.st == ST_NORMAL && fault.wdFail
      && r.wdCnt == FAIL_CNT) |=> r.st == ST_FAIL)
      else $error("fourth watchdog failure missed");
   a_fo_pin: assert property ((r.st == ST_FAIL && r.cfg.foSel)
      |-> !failPinOeN && !failPinOut)
      else $error("fail output pin not driven");
   a_cmd_err: assert property ((bus.wr && bus.addr == A_TMR0
      && {5'h00, tw.onCode} > tw.period) |=> r.cmdErr)
      else $error("on-time above period not flagged");
   a_cw_int: assert property ((r.st == ST_NORMAL && cwEv)
      |=> !interruptOutN [*3])
      else $error("cyclic wake interrupt missing");
   a_sense_flag: assert property ((r.st != ST_FAIL && |wkEv) |=> (r.wkFlag & $past(wkEv))
      == $past(wkEv))
      else $error("wake flag not set");
endmodule : fmw_core
`default_nettype wire

// *** verification/fmw_wake_switch.sv ***
// wake switch model standing at the wake pins of the core
`timescale 1ns/1ps
`default_nettype none
module fmw_wake_switch (
   // clock
   input wire logic sys_clk,
   // high-side supply and bench controls
   input wire logic [1:0] highSideOut,
   input wire logic [1:0] cyclic,
   input wire logic [1:0] closed,
   // wake pin levels
   output var logic [1:0] wakeLvl
);
   // switch to ground with pull-up; an unpowered cyclic input wanders each cycle
   initial wakeLvl = 2'h3;
   always @(posedge sys_clk)
   begin
      for (int i = 0; i < 2; i++)
      begin
         wakeLvl[i] <= (cyclic[i] && !highSideOut[i]) ? !wakeLvl[i] : !closed[i];
      end
   end
endmodule : fmw_wake_switch
`default_nettype wire

// *** verification/fmw_core_test.sv ***
// self-checking bench for the fault mode and wake timing core
`timescale 1ns/1ps
`default_nettype none
module fmw_core_test;
   import fmw_pkg::*;
   typedef struct {logic [8:0] f; logic [15:0] cfg; logic stop; logic [15:0] st;} fmw_row_s;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   fmw_bus_s bus = '0;
   fmw_fault_s fault = '0;
   logic [1:0] cyclic = 2'h0;
   logic [1:0] closed = 2'h0;
   logic [1:0] wakeLvl, wakeIn, highSideOut;
   logic [15:0] rdata;
   logic interruptOutN, resetOutN, failOutput, failPinOut, failPinOeN;
   int num_errors = 0;
   int compares = 0;
   int ki, kh, nw;
   // fault pulse, config, stop first, expected state
   fmw_row_s rows [6] = '{
      '{9'h100, 16'h0006, 1'b0, 16'h0008},
      '{9'h040, 16'h0006, 1'b1, 16'h0008},
      '{9'h080, 16'h0006, 1'b0, 16'h0008},
      '{9'h080, 16'h0007, 1'b1, 16'h0010},
      '{9'h010, 16'h0004, 1'b0, 16'h0010},
      '{9'h008, 16'h0006, 1'b1, 16'h0010}};
   logic [8:0] consec [2] = '{9'h040, 9'h100};
   logic [15:0] offCodes [3] = '{16'h0002, 16'h0602, 16'h0702};

   // shared pin level: the core drives it while its enable is low
   assign wakeIn = {failPinOeN ? wakeLvl[1] : failPinOut, wakeLvl[0]};

   fmw_core dut_u (.sys_clk, .rst_n, .bus, .rdata, .fault, .wakeIn, .interruptOutN,
      .resetOutN, .failOutput, .failPinOut, .failPinOeN, .highSideOut);
   fmw_wake_switch sw_u (.sys_clk, .highSideOut, .cyclic, .closed, .wakeLvl);

   // 100 MHz clock
   initial
   begin
      forever #5 sys_clk = ~sys_clk;
   end

   // ****************************************
   // bus, pulse and compare tasks
   // ****************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : cyc
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      bus <= {a, d, 2'h2};
      @(posedge sys_clk);
      bus <= '0;
   endtask : wr
   // read and compare the masked word
   task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
      @(posedge sys_clk);
      bus <= {a, 16'h0000, 2'h1};
      @(posedge sys_clk);
      bus <= '0;
      #1;
      chk(rdata & m, e);
   endtask : rd
   task automatic pulse(input logic [8:0] f);
      @(posedge sys_clk);
      fault <= f;
      @(posedge sys_clk);
      fault <= '0;
      #1;
   endtask : pulse
   // count low cycles of the interrupt and of high-side output 0
   task automatic watch(input int n);
      ki = 0;
      kh = 0;
      repeat (n)
      begin
         cyc(1);
         ki += !interruptOutN;
         kh += !highSideOut[0];
      end
   endtask : watch
   task automatic waitNormal();
      int n;
      n = 0;
      while (resetOutN !== 1'b1 && n < 1500)
      begin
         cyc(1);
         n++;
      end
      chk(resetOutN, 1'b1);
   endtask : waitNormal
   // static wake out of fail-safe, then clear the failure flag
   task automatic exitFail();
      @(posedge sys_clk);
      closed[0] <= !closed[0];
      waitNormal();
      rd(A_FLAG, 16'h0001, 16'h0001);
      chk(failOutput, 1'b1);
      wr(A_FLAG, 16'h0001);
      cyc(2);
      chk(failOutput, 1'b0);
   endtask : exitFail
   task automatic print_verdict();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : print_verdict

   // ****************************************
   // test sequence
   // ****************************************
   initial
   begin
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      cyc(1);
      chk({resetOutN, interruptOutN, failOutput, failPinOeN, highSideOut}, 16'h0014);
      cyc(2);
      rd(A_STATE, 16'h0008, 16'hffff);
      rd(4'hf, 16'h0000, 16'hffff);
      rd(A_CFG, 16'h0000, 16'hffff);
      waitNormal();
      // table of single faults
      foreach (rows[i])
      begin
         wr(A_CFG, rows[i].cfg);
         if (rows[i].stop)
            wr(A_STATE, 16'h0002);
         pulse(rows[i].f);
         rd(A_STATE, rows[i].st, 16'hffff);
         chk(resetOutN, 1'b0);
         if (rows[i].st == 16'h0010)
         begin
            chk({failOutput, failPinOeN, failPinOut}, {1'b1, !rows[i].cfg[1], 1'b0});
            exitFail();
         end
         else
            waitNormal();
      end
      // four consecutive failures of one kind
      foreach (consec[j])
      begin
         pulse(9'h020);
         for (int i = 0; i < 4; i++)
         begin
            pulse(consec[j]);
            rd(A_STATE, (i < 3) ? 16'h0008 : 16'h0010, 16'hffff);
            if (i < 3)
               waitNormal();
         end
         exitFail();
      end
      // sleep with no wake source, then with a wake flag pending
      wr(A_CFG, 16'h0000);
      wr(A_STATE, 16'h0003);
      rd(A_STATE, 16'h0008, 16'hffff);
      waitNormal();
      wr(A_CFG, 16'h0006);
      @(posedge sys_clk);
      closed[0] <= !closed[0];
      cyc(10);
      wr(A_STATE, 16'h0003);
      rd(A_STATE, 16'h0008, 16'hffff);
      waitNormal();
      wr(A_WAKE, 16'h0003);
      // on-time longer than period
      wr(A_TMR1, 16'h0502);
      rd(A_FLAG, 16'h0002, 16'h0002);
      wr(A_FLAG, 16'h0002);
      wr(A_TMR1, 16'h0000);
      // cyclic wake on timer 0
      wr(A_CFG, 16'h0016);
      foreach (offCodes[j])
      begin
         wr(A_TMR0, offCodes[j]);
         watch(500);
         chk(16'(ki), 16'h0000);
      end
      wr(A_TMR0, 16'h0102);
      // first interrupt only at the second tick after enabling, whatever the tick phase
      nw = 0;
      while (interruptOutN === 1'b1 && nw < 4 * TICK_CYC)
      begin
         cyc(1);
         nw++;
      end
      chk(16'(nw > TICK_CYC && nw <= 2 * TICK_CYC + 2), 16'h0001);
      watch(150);
      chk(16'(ki), 16'(INT_CYC - 1));
      wr(A_WAKE, 16'h0003);
      wr(A_STATE, 16'h0003);
      rd(A_STATE, 16'h0004, 16'hffff);
      waitNormal();
      wr(A_TMR0, 16'h0000);
      wr(A_CFG, 16'h0006);
      // cyclic sense on timer 0, high-side 0 and wake pin 0
      @(posedge sys_clk);
      cyclic <= 2'h1;
      closed <= 2'h0;
      wr(A_MAP, 16'h0051);
      cyc(2);
      chk(highSideOut[0], 1'b1);
      wr(A_TMR0, 16'h0204);
      watch(1000);
      chk(kh != 0, 1'b1);
      wr(A_WAKE, 16'h0003);
      rd(A_WAKE, 16'h0004, 16'h0005);
      @(posedge sys_clk);
      closed[0] <= 1'b1;
      watch(450);
      chk(ki != 0, 1'b1);
      rd(A_WAKE, 16'h0001, 16'h0005);
      @(posedge sys_clk);
      closed[0] <= 1'b0;
      watch(450);
      chk(ki != 0, 1'b1);
      pulse(9'h002);
      watch(500);
      chk(16'(kh), 16'h01f4);
      pulse(9'h008);
      rd(A_STATE, 16'h0010, 16'hffff);
      chk(highSideOut, 2'h0);
      print_verdict();
   end

   // watchdog well above the roughly 23000 cycles the sequence needs
   initial
   begin
      repeat (80000) @(posedge sys_clk);
      num_errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      print_verdict();
   end
endmodule : fmw_core_test
`default_nettype wire
